// >>> fms_feedback_sync.sv
// What this block does
// - analog feedback works only in normal mode; off in fail and sleep
// - a three-bit select field in init register 0 picks the source
// - sources are output 1 to 5 current, die temperature, supply voltage
// - current feedback off during inrush window, on in steady threshold phase
// - with pwm, current feedback only during the output on time
// - chop mode flips amplifier offset sign on each sync pin rising edge
// - per-channel chop enable bit, reset off, forced off in fail mode
// - chop on halves full scale and steady overcurrent threshold of channel
// - sync pin is open drain, active low, released outside normal mode
// - sync mode 00 keeps the pin released high for a current source while the pwm clock runs
// - mode 01 drives low while feedback valid, high while switching
// - mode 10 as 01, but after a select change waits next pwm cycle
// - mode 11 pulses low from pulse midpoint to end, blanked after change
// - no sync pulse during inrush window or pwm off phase while the pwm clock runs
// - for a current source, sync held high a fixed blanking time after select or chop change while the pwm clock runs
// - on pwm clock failure sync gives 50% square wave of 6.5 ms
// - at 100% duty in modes 10/11 pin low, 100 us high per overflow
// - while the pwm clock runs, after an output fault no sync triggers until it is enabled again or select or chop changes
// - temperature or supply selected: 50% square wave, period clock/1024
module fms_feedback_sync
  import fms_pkg::*;
#(
  parameter int FALLBACK_HALF = FALLBACK_HALF_CYC,
  parameter int HIGH_PULSE = HIGH_PULSE_CYC,
  parameter int BLANK = BLANK_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire fms_mode_e opMode,
  input wire fms_chan_s chan,
  input wire fms_pwm_s pwm,
  input wire logic syncPinIn,
  output logic syncPinOut,
  output logic syncPinOeN,
  output logic fbEnable,
  output fms_src_e fbSource,
  output logic chopSign,
  output logic [4:0] halfScale
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // select lookup
  function automatic fms_src_e decodeSel(input logic [2:0] code);
    fms_src_e s;
    s = SRC_NONE;
    if (code == SEL_CODE_OUT1) s = SRC_OUT1;
    if (code == SEL_CODE_OUT2) s = SRC_OUT2;
    if (code == SEL_CODE_OUT3) s = SRC_OUT3;
    if (code == SEL_CODE_OUT4) s = SRC_OUT4;
    if (code == SEL_CODE_OUT5) s = SRC_OUT5;
    if (code == SEL_CODE_TEMP) s = SRC_TEMP;
    if (code == SEL_CODE_VSUP) s = SRC_VSUP;
    return s;
  endfunction

  // ---------------- ahb-lite slave, zero wait states
  logic [2:0] selCode_q;
  logic [1:0] syncMode_q;
  logic [4:0] chopEn_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  wire addrPhase = hsel && htrans[1] && hready;
  wire [7:0] aAddr = haddr[7:0];
  wire mapped = (haddr[31:8] == 24'h000000) && (aAddr == ADDR_INIT0 || aAddr == ADDR_CHOP
                || aAddr == ADDR_STATUS);

  // core state visible through the status register
  logic syncAct_q;
  logic chopSign_q;
  logic faultBlock_q;
  logic [CNT_W-1:0] blankCnt_q;
  wire [31:0] statusWord = {27'h0, blankCnt_q != '0, faultBlock_q, chopSign_q, syncAct_q,
                            opMode == MODE_NORMAL};
  wire [31:0] readWord = !mapped ? 32'h0 :
                         (aAddr == ADDR_INIT0) ? {27'h0, syncMode_q, selCode_q} :
                         (aAddr == ADDR_CHOP) ? {27'h0, chopEn_q} : statusWord;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      wrPend_q <= addrPhase && hwrite && mapped;
      wrAddr_q <= aAddr;
      if (addrPhase && !hwrite)
        hrdata_q <= readWord;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      selCode_q <= SEL_RESET;
      syncMode_q <= SYNC_RESET;
      chopEn_q <= CHOP_RESET;
    end
    else if (wrPend_q && wrAddr_q == ADDR_INIT0)
    begin
      selCode_q <= hwdata[SEL_LSB +: 3];
      syncMode_q <= hwdata[SYNC_LSB +: 2];
    end
    else if (wrPend_q && wrAddr_q == ADDR_CHOP)
      chopEn_q <= hwdata[4:0];
  end

  // ---------------- source decode
  // code to source
  wire fms_src_e src = decodeSel(selCode_q);
  // current sources are outputs 1 to 5
  wire isCur = (src >= SRC_OUT1) && (src <= SRC_OUT5);
  wire isVolt = (src == SRC_TEMP) || (src == SRC_VSUP);
  wire [2:0] chIdx = 3'(src) - 3'h1;
  wire normal = (opMode == MODE_NORMAL);

  wire selOn = isCur && chan.outOn[chIdx];
  wire selInrush = isCur && chan.inrushWin[chIdx];
  wire selFault = isCur && chan.fault[chIdx];
  wire selEn = isCur && chan.enabled[chIdx];
  wire selFull = isCur && chan.fullDuty[chIdx];

  // chop forced off in fail mode
  wire [4:0] chopEff = (opMode == MODE_FAIL) ? 5'h00 : chopEn_q;
  wire selChop = isCur && chopEff[chIdx];

  // ---------------- change detection and blanking
  logic [2:0] selPrev_q;
  logic chopPrev_q;
  logic enPrev_q;
  logic syncInPrev_q;
  logic waitCycle_q;
  logic waitMid_q;
  logic [CNT_W-1:0] pulseCnt_q;
  logic [CNT_W-1:0] onCnt_q;
  logic [CNT_W-1:0] lastOn_q;

  wire srcChange = (selCode_q != selPrev_q) || (selChop != chopPrev_q);
  wire blanking = (blankCnt_q != '0);
  wire syncRise = syncPinIn && !syncInPrev_q;
  wire midReached = (onCnt_q >= (lastOn_q >> 1));

  // blanking after a select or chop change
  wire [CNT_W-1:0] blankCnt_d = srcChange ? CNT_W'(BLANK) :
                                blanking ? blankCnt_q - 1'b1 : blankCnt_q;

  // hold off triggers after a fault until re-enabled or a select or chop change; a new fault wins
  wire faultBlock_d = selFault ? 1'b1 :
                      (srcChange || (selEn && !enPrev_q)) ? 1'b0 : faultBlock_q;

  // after a change wait for the next pwm cycle; the change wins
  wire waitCycle_d = srcChange ? 1'b1 : pwm.cycleStart ? 1'b0 : waitCycle_q;

  // after a change wait for the next midpoint, counted after blanking
  wire waitMid_d = srcChange ? 1'b1 :
                   (selOn && midReached && !blanking) ? 1'b0 : waitMid_q;

  // 100 us high pulse at each pwm counter overflow
  wire [CNT_W-1:0] pulseCnt_d = pwm.overflow ? CNT_W'(HIGH_PULSE) :
                                (pulseCnt_q != '0) ? pulseCnt_q - 1'b1 : pulseCnt_q;

  // on-time measure for the midpoint; saturates rather than wrapping
  wire onSat = &onCnt_q;
  wire [CNT_W-1:0] onCnt_d = !selOn ? '0 : onSat ? onCnt_q : onCnt_q + 1'b1;
  wire [CNT_W-1:0] lastOn_d = (!selOn && onCnt_q != '0) ? onCnt_q : lastOn_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      selPrev_q <= SEL_RESET;
      chopPrev_q <= 1'b0;
      enPrev_q <= 1'b0;
      syncInPrev_q <= 1'b1;
      blankCnt_q <= '0;
      faultBlock_q <= 1'b0;
      waitCycle_q <= 1'b0;
      waitMid_q <= 1'b0;
      pulseCnt_q <= '0;
      onCnt_q <= '0;
      lastOn_q <= '0;
    end
    else
    begin
      selPrev_q <= selCode_q;
      chopPrev_q <= selChop;
      enPrev_q <= selEn;
      syncInPrev_q <= syncPinIn;
      blankCnt_q <= blankCnt_d;
      faultBlock_q <= faultBlock_d;
      waitCycle_q <= waitCycle_d;
      waitMid_q <= waitMid_d;
      pulseCnt_q <= pulseCnt_d;
      onCnt_q <= onCnt_d;
      lastOn_q <= lastOn_d;
    end
  end

  // ---------------- square waves
  logic fallbackWave;
  logic prescaleWave;

  // fixed fallback period, counted on the system clock
  fms_square #(.HALF(FALLBACK_HALF)) uFallback (
    .clk(clk),
    .rst(rst),
    .run(normal && pwm.clkFail),
    .tick(1'b1),
    .wave(fallbackWave)
  );

  // lowest prescaler period, counted on pwm clock ticks
  fms_square #(.HALF(PRESCALE_HALF_TICKS)) uPrescale (
    .clk(clk),
    .rst(rst),
    .run(normal && isVolt),
    .tick(pwm.clkTick),
    .wave(prescaleWave)
  );

  // ---------------- sync decision, 1 = pin pulled low
  // no trigger in inrush window, off phase, fault or blanking
  wire curGate = !selInrush && !faultBlock_q && !blanking;
  wire fullPath = selFull && (syncMode_q == SYNC_NEXT_CYCLE || syncMode_q == SYNC_MIDPOINT);
  logic curAct;

  always_comb
  begin
    curAct = 1'b0;
    unique case (syncMode_q)
      SYNC_OFF: curAct = 1'b0;
      SYNC_VALID: curAct = selOn;
      // valid after the next cycle start
      SYNC_NEXT_CYCLE: curAct = selOn && !waitCycle_q;
      SYNC_MIDPOINT: curAct = selOn && midReached && !waitMid_q;
    endcase
    // full duty: low except the overflow pulse
    if (fullPath)
      curAct = !waitCycle_q && (pulseCnt_q == '0);
    curAct = curAct && curGate;
  end

  // only in normal mode; clock failure overrides source type
  wire syncAct_d = !normal ? 1'b0 :
                   pwm.clkFail ? fallbackWave :
                   isVolt ? prescaleWave :
                   isCur && curAct;

  // ---------------- analog path control
  // feedback only in normal mode, steady phase, on time
  wire fbEnable_d = normal && (isVolt || (isCur && !selInrush && selOn));
  // offset sign flips on each sync rising edge while chopping
  wire chopSign_d = (normal && selChop && syncRise) ? ~chopSign_q : chopSign_q;

  logic fbEnable_q;
  fms_src_e fbSource_q;
  logic [4:0] halfScale_q;
  logic syncPinOut_q;
  logic syncOeN_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syncAct_q <= 1'b0;
      syncPinOut_q <= 1'b0;
      syncOeN_q <= 1'b1;
      fbEnable_q <= 1'b0;
      fbSource_q <= SRC_NONE;
      chopSign_q <= 1'b0;
      halfScale_q <= 5'h00;
    end
    else
    begin
      syncAct_q <= syncAct_d;
      syncPinOut_q <= 1'b0;
      syncOeN_q <= ~syncAct_d;
      fbEnable_q <= fbEnable_d;
      fbSource_q <= normal ? src : SRC_NONE;
      chopSign_q <= chopSign_d;
      // halved range and threshold per chopping channel
      halfScale_q <= chopEff;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  // open drain: only ever pulls low, enable low while pulling
  assign syncPinOut = syncPinOut_q;
  assign syncPinOeN = syncOeN_q;
  assign fbEnable = fbEnable_q;
  assign fbSource = fbSource_q;
  assign chopSign = chopSign_q;
  assign halfScale = halfScale_q;

  // ---------------- checks
  sequence chopEdge;
    normal && selChop && syncRise;
  endsequence

  a_sync_released_idle: assert property (!normal |=> syncPinOeN && !fbEnable)
    else $error("sync or feedback active outside normal mode");
  a_fb_mode_gate: assert property ((opMode == MODE_SLEEP) [*2] |-> !fbEnable)
    else $error("feedback enabled in sleep mode");
  a_sync_mode_off: assert property (normal && isCur && !pwm.clkFail
    && syncMode_q == SYNC_OFF |=> syncPinOeN)
    else $error("sync pulled low in mode off");
  a_chop_sign_flip: assert property (chopEdge |=> chopSign != $past(chopSign))
    else $error("offset sign did not flip on sync rise");
  a_chop_fail_off: assert property (opMode == MODE_FAIL |=> halfScale == 5'h00)
    else $error("chop active in fail mode");
  a_blank_hold: assert property (srcChange && isCur && !pwm.clkFail |=>
    blankCnt_q == CNT_W'(BLANK) ##1 syncPinOeN)
    else $error("sync not blanked after change");
  a_fault_no_trig: assert property (faultBlock_q && isCur && !pwm.clkFail
    |=> syncPinOeN)
    else $error("sync trigger after output fault");
  a_inrush_quiet: assert property (selInrush |=> !fbEnable &&
    (syncPinOeN || $past(pwm.clkFail)))
    else $error("feedback or sync during inrush");
  a_off_phase: assert property (isCur && !selOn |=> !fbEnable)
    else $error("current feedback during off time");
  a_wait_cycle: assert property (normal && isCur && syncMode_q == SYNC_NEXT_CYCLE
    && waitCycle_q && !pwm.clkFail |=> syncPinOeN)
    else $error("sync low before next pwm cycle");

endmodule

// >>> fms_pkg.sv
package fms_pkg;

  // operating mode of the switch as seen by this block
  typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FAIL} fms_mode_e;

  // feedback sources
  typedef enum logic [2:0] {
    SRC_NONE, SRC_OUT1, SRC_OUT2, SRC_OUT3, SRC_OUT4, SRC_OUT5, SRC_TEMP, SRC_VSUP
  } fms_src_e;

  // sync mode field values
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_VALID = 2'h1;
  localparam logic [1:0] SYNC_NEXT_CYCLE = 2'h2;
  localparam logic [1:0] SYNC_MIDPOINT = 2'h3;

  // select field codes, one per source; edit to match the register definition
  localparam logic [2:0] SEL_CODE_OUT1 = 3'h1;
  localparam logic [2:0] SEL_CODE_OUT2 = 3'h2;
  localparam logic [2:0] SEL_CODE_OUT3 = 3'h3;
  localparam logic [2:0] SEL_CODE_OUT4 = 3'h4;
  localparam logic [2:0] SEL_CODE_OUT5 = 3'h5;
  localparam logic [2:0] SEL_CODE_TEMP = 3'h6;
  localparam logic [2:0] SEL_CODE_VSUP = 3'h7;

  // register map, byte addresses
  localparam logic [7:0] ADDR_INIT0 = 8'h00;
  localparam logic [7:0] ADDR_CHOP = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // init0 field layout
  localparam int SEL_LSB = 0;
  localparam int SYNC_LSB = 3;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [4:0] CHOP_RESET = 5'h00;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_FALLBACK_PERIOD_NS = 6500000;
  localparam int FALLBACK_HALF_CYC = T_FALLBACK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int T_HIGH_PULSE_NS = 100000;
  localparam int HIGH_PULSE_CYC = T_HIGH_PULSE_NS / CLK_PERIOD_NS;
  localparam int T_DLY_ON_NS = 40000;
  localparam int T_ANALOG_FEEDBACK_PIN_SET_NS = 60000;
  localparam int BLANK_CYC = (T_DLY_ON_NS + T_ANALOG_FEEDBACK_PIN_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESCALE_DIV = 1024;
  localparam int PRESCALE_HALF_TICKS = PRESCALE_DIV / 2;
  localparam int CNT_W = 21;

  // per-channel state from the switch core
  typedef struct packed {
    logic [4:0] outOn;
    logic [4:0] inrushWin;
    logic [4:0] fault;
    logic [4:0] enabled;
    logic [4:0] fullDuty;
  } fms_chan_s;

  // events from the pwm clock and counter
  typedef struct packed {
    logic cycleStart;
    logic overflow;
    logic clkTick;
    logic clkFail;
  } fms_pwm_s;

endpackage

// >>> fms_square.sv
module fms_square
  import fms_pkg::*;
#(
  parameter int HALF = 512
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  output logic wave
);

  logic [CNT_W-1:0] cnt_q;
  logic wave_q;
  wire lastTick = (cnt_q == CNT_W'(HALF - 1));

  // restarts from the low half whenever it is not in use
  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      cnt_q <= '0;
      wave_q <= 1'b0;
    end
    else if (tick)
    begin
      cnt_q <= lastTick ? '0 : cnt_q + 1'b1;
      if (lastTick)
        wave_q <= ~wave_q;
    end
  end

  assign wave = wave_q;

endmodule

// >>> fms_host_mcu.sv
module fms_host_mcu
  import fms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic syncPinOut,
  input wire logic syncPinOeN,
  input wire logic fbEnable,
  output logic syncPinIn,
  output logic [15:0] nSamples
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pinLast_q;
  // pull-up on the wire: a released pin reads high, never the last driven level
  assign syncPinIn = syncPinOeN ? 1'b1 : syncPinOut;
  // the adc starts a conversion on each falling sync edge while feedback is on
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinLast_q <= 1'b1;
      nSamples <= 16'h0;
    end
    else
    begin
      pinLast_q <= syncPinIn;
      if (pinLast_q && !syncPinIn && fbEnable)
      begin
        nSamples <= nSamples + 16'h1;
      end
    end
  end
endmodule

// >>> tb_top.sv
module tb_top
  import fms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BL = 6;
  localparam int HP = 5;
  localparam logic [31:0] M_OEN = 32'h1;
  localparam logic [31:0] M_FBE = 32'h2;
  localparam logic [31:0] M_SRC = 32'h1c;
  localparam logic [31:0] M_CHS = 32'h20;
  localparam logic [31:0] M_HS = 32'h7c0;
  typedef struct packed {logic [31:0] m; logic [31:0] v;} fms_note_s;
  logic clk, rst, hwrite, hready, hreadyout, hresp, syncPinIn, syncPinOut, syncPinOeN;
  logic fbEnable, chopSign, look, rdPh;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans;
  logic [4:0] halfScale;
  logic [15:0] nSamples;
  fms_mode_e opMode;
  fms_chan_s chan;
  fms_pwm_s pwm;
  fms_src_e fbSource;
  fms_note_s rdQ[$], lkQ[$], ent;
  int errCount = 0;
  int nChecks = 0;
  logic [2:0] codes [7];
  wire logic [31:0] obs = {21'h0, halfScale, chopSign, fbSource, fbEnable, syncPinOeN};
  assign hready = hreadyout;

  fms_feedback_sync #(.FALLBACK_HALF(8), .HIGH_PULSE(HP), .BLANK(BL)) dut (
    .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .opMode(opMode), .chan(chan), .pwm(pwm), .syncPinIn(syncPinIn),
    .syncPinOut(syncPinOut), .syncPinOeN(syncPinOeN), .fbEnable(fbEnable),
    .fbSource(fbSource), .chopSign(chopSign), .halfScale(halfScale)
  );
  fms_host_mcu host (
    .clk(clk), .rst(rst), .syncPinOut(syncPinOut), .syncPinOeN(syncPinOeN),
    .fbEnable(fbEnable), .syncPinIn(syncPinIn), .nSamples(nSamples)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a slave that never answers must not hang the run
  task automatic waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1)
    begin
      errCount++;
      conclude();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    waitReady();
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    if (!w)
    begin
      rdQ.push_back('{m: 32'hffffffff, v: e});
      rdPh <= 1'b1;
    end
    waitReady();
    rdPh <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, e);
  endtask

  // outputs are levels: let the causing edge settle before looking
  task automatic probe(input logic [31:0] m, input logic [31:0] v);
    repeat (3) @(posedge clk);
    lkQ.push_back('{m: m, v: v & m});
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask

  task automatic pulse(input int i);
    pwm[i] <= 1'b1;
    @(posedge clk);
    pwm[i] <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    if (rdPh && hreadyout === 1'b1 && rdQ.size() > 0)
    begin
      ent = rdQ.pop_front();
      check(hrdata, ent.v);
      check({31'h0, hresp}, 32'h0);
      check({31'h0, syncPinOut}, 32'h0);
    end
    if (look && lkQ.size() > 0)
    begin
      ent = lkQ.pop_front();
      check(obs & ent.m, ent.v);
    end
  end

  initial
  begin
    rst = 1'b1;
    opMode = MODE_NORMAL;
    chan = '0;
    pwm = '0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    look = 1'b0;
    rdPh = 1'b0;
    rnd = 32'h74d54834;
    codes = '{SEL_CODE_OUT1, SEL_CODE_OUT2, SEL_CODE_OUT3, SEL_CODE_OUT4,
              SEL_CODE_OUT5, SEL_CODE_TEMP, SEL_CODE_VSUP};
    idle(12);
    rst <= 1'b0;
    chan.enabled <= 5'h1f;
    rd(ADDR_INIT0, 32'h0);
    rd(ADDR_CHOP, 32'h0);
    rnd = lfsr(rnd);
    rd(8'h0c + {rnd[3:0], 4'h0}, 32'h0);
    rnd = lfsr(rnd);
    wr(ADDR_INIT0, rnd);
    rd(ADDR_INIT0, {27'h0, rnd[4:0]});
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_INIT0, {27'h0, SYNC_VALID, codes[i]});
      probe(M_SRC, {27'h0, 3'(i + 1), 2'h0});
    end
    // switch from an idle output to a conducting one
    wr(ADDR_INIT0, {27'h0, SYNC_VALID, SEL_CODE_OUT2});
    chan.outOn <= 5'h01;
    wr(ADDR_INIT0, {27'h0, SYNC_VALID, SEL_CODE_OUT1});
    probe(M_OEN, 32'h1);
    idle(BL);
    probe(M_OEN | M_FBE, 32'h2);
    chan.inrushWin <= 5'h01;
    probe(M_OEN | M_FBE, 32'h1);
    chan.inrushWin <= 5'h00;
    probe(M_OEN | M_FBE, 32'h2);
    chan.outOn <= 5'h00;
    probe(M_OEN | M_FBE, 32'h1);
    chan.fault <= 5'h01;
    chan.enabled <= 5'h00;
    chan.outOn <= 5'h01;
    idle(2);
    chan.fault <= 5'h00;
    probe(M_OEN, 32'h1);
    chan.enabled <= 5'h1f;
    probe(M_OEN, 32'h0);
    // chop on while the pin is released, so the first rise is a real one
    chan.outOn <= 5'h00;
    wr(ADDR_CHOP, 32'h1);
    probe(M_HS | M_OEN, 32'h41);
    idle(BL);
    chan.outOn <= 5'h01;
    probe(M_OEN | M_CHS, 32'h0);
    chan.outOn <= 5'h00;
    probe(M_OEN | M_CHS, 32'h21);
    rd(ADDR_CHOP, 32'h1);
    chan.outOn <= 5'h01;
    for (int k = 0; k < 2; k++)
    begin
      opMode <= k ? MODE_FAIL : MODE_SLEEP;
      // chop is only forced off in fail mode; sleep keeps the enabled range
      probe(M_OEN | M_FBE | M_SRC | M_HS, k ? 32'h1 : 32'h41);
    end
    opMode <= MODE_NORMAL;
    wr(ADDR_INIT0, {27'h0, SYNC_OFF, SEL_CODE_OUT1});
    idle(BL);
    probe(M_OEN, 32'h1);
    wr(ADDR_INIT0, {27'h0, SYNC_NEXT_CYCLE, SEL_CODE_OUT2});
    wr(ADDR_INIT0, {27'h0, SYNC_NEXT_CYCLE, SEL_CODE_OUT1});
    idle(BL);
    probe(M_OEN, 32'h1);
    pulse(3);
    probe(M_OEN, 32'h0);
    chan.fullDuty <= 5'h01;
    pulse(2);
    probe(M_OEN, 32'h1);
    idle(HP);
    probe(M_OEN, 32'h0);
    chan.fullDuty <= 5'h00;
    wr(ADDR_INIT0, {27'h0, SYNC_VALID, SEL_CODE_TEMP});
    repeat (256)
    begin
      pulse(1);
      @(posedge clk);
    end
    probe(M_OEN, 32'h1);
    repeat (512)
    begin
      pulse(1);
      @(posedge clk);
    end
    probe(M_OEN, 32'h0);
    pwm.clkFail <= 1'b1;
    idle(1);
    probe(M_OEN, 32'h1);
    idle(4);
    probe(M_OEN, 32'h0);
    pwm.clkFail <= 1'b0;
    idle(4);
    // mode 11: a short first pulse sets the on time, the next one is split at its middle
    chan.outOn <= 5'h00;
    wr(ADDR_INIT0, {27'h0, SYNC_MIDPOINT, SEL_CODE_OUT1});
    idle(BL);
    chan.outOn <= 5'h01;
    idle(8);
    chan.outOn <= 5'h00;
    idle(2);
    chan.outOn <= 5'h01;
    probe(M_OEN, 32'h1);
    idle(8);
    probe(M_OEN, 32'h0);
    check({31'h0, nSamples != 16'h0}, 32'h1);
    conclude();
  end
endmodule
